/* common/ppe_pkg.sv */
package ppe_pkg;

    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int OFS_W = 3;
    localparam int CTL_W = 6;
    localparam int REQ_W = 1 + OFS_W + DATA_W;
    localparam int FIFO_DEPTH = 8;

    // -------------------------------------------------------------------
    // Port offsets from the base address
    // -------------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_DATA = 3'h0;
    localparam logic [OFS_W-1:0] OFS_STATUS = 3'h1;
    localparam logic [OFS_W-1:0] OFS_CONTROL = 3'h2;
    localparam logic [OFS_W-1:0] OFS_EPP_ADDR = 3'h3;
    localparam logic [OFS_W-1:0] OFS_EPP_DATA0 = 3'h4;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_ONLINE_BIT = 4;
    localparam int ST_PAPER_BIT = 5;
    localparam int ST_ACK_BIT = 6;
    localparam int ST_READY_BIT = 7;
    localparam int CT_STROBE_BIT = 0;
    localparam int CT_LINEFEED_BIT = 1;
    localparam int CT_INIT_BIT = 2;
    localparam int CT_SELECT_BIT = 3;
    localparam int CT_IRQ_EN_BIT = 4;
    localparam int CT_DIR_BIT = 5;
    localparam int REQ_WRITE_BIT = REQ_W - 1;

    // -------------------------------------------------------------------
    // Reset and fixed values
    // -------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
    localparam logic [DATA_W-1:0] EPP_ABSENT_READ = 8'hFF;

    // -------------------------------------------------------------------
    // Port modes
    // -------------------------------------------------------------------
    localparam logic [1:0] MODE_PRINTER = 2'h0;
    localparam logic [1:0] MODE_BIDIR = 2'h1;
    localparam logic [1:0] MODE_EPP = 2'h2;
    localparam logic [1:0] MODE_ECP = 2'h3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int EPP_TIMEOUT_US = 10;
    localparam int TMO_CYCLES = EPP_TIMEOUT_US * CLK_MHZ;
    localparam int TMO_W = 12;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRE,
        ST_STB
    } ppe_state_type;

endpackage

/* hw/ppe_mem.sv */
`timescale 1ns/100ps
module ppe_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-first bypass so a word written into an empty queue is seen at once.
    always_ff @(posedge clk) begin
        if (we && (waddr == raddr)) begin
            rdata_r <= wdata;
        end else begin
            rdata_r <= mem[raddr];
        end
    end

    assign rdata = rdata_r;

endmodule

/* hw/ppe_fifo.sv */
`timescale 1ns/100ps
module ppe_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = AW'(0) + (AW+1)'(DEPTH);

    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic ready_r;
    logic push;
    logic pop;

    assign push = in_valid && ready_r;
    assign pop = out_valid && out_ready;
    assign rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            ready_r <= (count_nxt != FULL_COUNT);
        end
    end

    ppe_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk(clk),
        .we(push),
        .waddr(wr_ptr_r),
        .wdata(in_data),
        .raddr(rd_ptr_nxt),
        .rdata(out_data)
    );

    assign in_ready = ready_r;
    assign out_valid = (count_r != '0);

endmodule

/* hw/ppe_port.sv */
`timescale 1ns/100ps
module ppe_port (
    input wire logic clk,
    input wire logic rst_n,
    // Host I/O side.
    input wire logic io_valid,
    output logic io_ready,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic io_done,
    output logic [7:0] io_rdata,
    // Configuration.
    input wire logic [15:0] base_addr,
    input wire logic [1:0] port_mode,
    input wire logic tmo_clear_mode,
    // Cable side.
    input wire logic [7:0] port_data_pins_in,
    output logic [7:0] port_data_pins_out,
    output logic port_data_pins_oe,
    output logic strobe_pin_n,
    output logic linefeed_pin,
    output logic init_pin,
    output logic select_in_pin,
    input wire logic fault_pin,
    input wire logic online_pin,
    input wire logic paper_out_pin,
    input wire logic acknowledge_in,
    input wire logic wait_pin_n,
    output logic ack_irq
);

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    localparam int SYNC_W = ppe_pkg::DATA_W + 5;

    logic [SYNC_W-1:0] pin_meta_r;
    logic [SYNC_W-1:0] pin_sync_r;
    logic [ppe_pkg::DATA_W-1:0] pd_sync;
    logic fault_sync, online_sync, paper_sync, ack_sync;
    logic wait_sync_n;
    logic ack_prev_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {port_data_pins_in, fault_pin, online_pin, paper_out_pin,
                           acknowledge_in, wait_pin_n};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign pd_sync = pin_sync_r[SYNC_W-1:5];
    assign fault_sync = pin_sync_r[4];
    assign online_sync = pin_sync_r[3];
    assign paper_sync = pin_sync_r[2];
    assign ack_sync = pin_sync_r[1];
    assign wait_sync_n = pin_sync_r[0];

    // -------------------------------------------------------------------
    // Address decode and request queue
    // -------------------------------------------------------------------
    // Accesses outside the eight-byte window are accepted and dropped; another
    // device on the host bus answers them.
    logic addr_hit;
    logic fifo_in_valid;
    logic [ppe_pkg::REQ_W-1:0] fifo_in_data;
    logic req_valid, req_ready;
    logic [ppe_pkg::REQ_W-1:0] req_data;
    logic req_write;
    logic [ppe_pkg::OFS_W-1:0] req_ofs;
    logic [ppe_pkg::DATA_W-1:0] req_wdata;
    logic fifo_ready;

    assign addr_hit = (io_addr[ppe_pkg::ADDR_W-1:ppe_pkg::OFS_W]
                       == base_addr[ppe_pkg::ADDR_W-1:ppe_pkg::OFS_W]);
    assign fifo_in_valid = io_valid && addr_hit;
    assign fifo_in_data = {io_write, io_addr[ppe_pkg::OFS_W-1:0], io_wdata};

    ppe_fifo #(.WIDTH(ppe_pkg::REQ_W), .DEPTH(ppe_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_ready),
        .in_data(fifo_in_data),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data(req_data)
    );

    assign io_ready = fifo_ready;
    assign req_write = req_data[ppe_pkg::REQ_WRITE_BIT];
    assign req_ofs = req_data[ppe_pkg::REQ_WRITE_BIT-1:ppe_pkg::DATA_W];
    assign req_wdata = req_data[ppe_pkg::DATA_W-1:0];

    // -------------------------------------------------------------------
    // Request engine
    // -------------------------------------------------------------------
    ppe_pkg::ppe_state_type state_r;
    logic [ppe_pkg::TMO_W-1:0] tmo_cnt_r;
    logic epp_mode, is_epp_ofs, take, start_epp, tmo_hit, cycle_ok;
    logic epp_wr_r, epp_is_addr_r;
    logic [ppe_pkg::DATA_W-1:0] data_r;
    logic [ppe_pkg::DATA_W-1:0] epp_addr_r;
    logic [ppe_pkg::DATA_W-1:0] epp_data_r;
    logic [ppe_pkg::CTL_W-1:0] ctl_r;
    logic tmo_flag_r;
    logic [ppe_pkg::DATA_W-1:0] status_now;
    logic [ppe_pkg::DATA_W-1:0] local_rdata;
    logic done_r;
    logic [ppe_pkg::DATA_W-1:0] rdata_r;

    assign epp_mode = (port_mode == ppe_pkg::MODE_EPP);
    assign is_epp_ofs = (req_ofs >= ppe_pkg::OFS_EPP_ADDR);
    assign req_ready = (state_r == ppe_pkg::ST_IDLE);
    assign take = req_valid && req_ready;
    assign start_epp = take && is_epp_ofs && epp_mode;
    assign tmo_hit = (state_r != ppe_pkg::ST_IDLE)
                     && (tmo_cnt_r == ppe_pkg::TMO_W'(ppe_pkg::TMO_CYCLES - 1));
    // Peripheral released wait while its strobe is up: the cycle may finish.
    assign cycle_ok = (state_r == ppe_pkg::ST_STB) && wait_sync_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ppe_pkg::ST_IDLE;
        end else begin
            case (state_r)
                ppe_pkg::ST_IDLE: begin
                    if (start_epp) begin
                        state_r <= ppe_pkg::ST_PRE;
                    end
                end
                ppe_pkg::ST_PRE: begin
                    if (tmo_hit) begin
                        state_r <= ppe_pkg::ST_IDLE;
                    end else if (!wait_sync_n) begin
                        state_r <= ppe_pkg::ST_STB;
                    end
                end
                ppe_pkg::ST_STB: begin
                    if (tmo_hit || cycle_ok) begin
                        state_r <= ppe_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ppe_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // The limit counts from the start of the EPP cycle, wait phase included.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmo_cnt_r <= '0;
        end else if (state_r == ppe_pkg::ST_IDLE) begin
            tmo_cnt_r <= '0;
        end else begin
            tmo_cnt_r <= tmo_cnt_r + ppe_pkg::TMO_W'(1);
        end
    end

    // A write with the direction bit set turns into a read on the cable.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            epp_wr_r <= 1'b0;
            epp_is_addr_r <= 1'b0;
        end else if (start_epp) begin
            epp_wr_r <= req_write && !ctl_r[ppe_pkg::CT_DIR_BIT];
            epp_is_addr_r <= (req_ofs == ppe_pkg::OFS_EPP_ADDR);
        end
    end

    // -------------------------------------------------------------------
    // Port registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_r <= ppe_pkg::DATA_RESET;
        end else if (take && req_write && req_ofs == ppe_pkg::OFS_DATA) begin
            data_r <= req_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_r <= ppe_pkg::CTL_RESET;
        end else if (take && req_write && req_ofs == ppe_pkg::OFS_CONTROL) begin
            ctl_r <= req_wdata[ppe_pkg::CTL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            epp_addr_r <= ppe_pkg::DATA_RESET;
        end else if (start_epp && req_write && req_ofs == ppe_pkg::OFS_EPP_ADDR) begin
            epp_addr_r <= req_wdata;
        end
    end

    // One latch serves all four data windows since they share the cable.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            epp_data_r <= ppe_pkg::DATA_RESET;
        end else if (start_epp && req_write && req_ofs >= ppe_pkg::OFS_EPP_DATA0) begin
            epp_data_r <= req_wdata;
        end
    end

    // Setting wins over either clear so a timeout is never lost.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmo_flag_r <= 1'b0;
        end else if (tmo_hit) begin
            tmo_flag_r <= 1'b1;
        end else if (take && req_ofs == ppe_pkg::OFS_STATUS) begin
            if (req_write && !tmo_clear_mode && req_wdata[ppe_pkg::ST_TIMEOUT_BIT]) begin
                tmo_flag_r <= 1'b0;
            end else if (!req_write && tmo_clear_mode) begin
                tmo_flag_r <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    always_comb begin
        status_now = '0;
        status_now[ppe_pkg::ST_TIMEOUT_BIT] = tmo_flag_r;
        status_now[ppe_pkg::ST_FAULT_BIT] = fault_sync;
        status_now[ppe_pkg::ST_ONLINE_BIT] = online_sync;
        status_now[ppe_pkg::ST_PAPER_BIT] = paper_sync;
        status_now[ppe_pkg::ST_ACK_BIT] = ack_sync;
        status_now[ppe_pkg::ST_READY_BIT] = !wait_sync_n;
    end

    always_comb begin
        case (req_ofs)
            ppe_pkg::OFS_DATA: begin
                // Printer mode reads the pins; other modes read them too, since
                // with the direction bit clear the pins carry the latch.
                local_rdata = pd_sync;
            end
            ppe_pkg::OFS_STATUS: begin
                local_rdata = status_now;
            end
            ppe_pkg::OFS_CONTROL: begin
                local_rdata = {{(ppe_pkg::DATA_W - ppe_pkg::CTL_W){1'b0}}, ctl_r};
            end
            default: begin
                local_rdata = ppe_pkg::EPP_ABSENT_READ;
            end
        endcase
    end

    // The answer is captured once and held until the next answer, so the
    // host sees a steady status byte for its whole read.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (take && !start_epp && !req_write) begin
            rdata_r <= local_rdata;
        end else if (cycle_ok && !epp_wr_r) begin
            rdata_r <= pd_sync;
        end else if (tmo_hit && !epp_wr_r) begin
            rdata_r <= pd_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (take && !start_epp) || cycle_ok || tmo_hit;
        end
    end

    assign io_done = done_r;
    assign io_rdata = rdata_r;

    // -------------------------------------------------------------------
    // Cable outputs
    // -------------------------------------------------------------------
    logic epp_busy, strobe_up;
    logic [ppe_pkg::DATA_W-1:0] pd_out_r;
    logic pd_oe_r, strobe_r, linefeed_r, init_r, select_r;

    assign epp_busy = (state_r != ppe_pkg::ST_IDLE);
    assign strobe_up = (state_r == ppe_pkg::ST_STB) && !cycle_ok && !tmo_hit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_out_r <= ppe_pkg::DATA_RESET;
        end else if (epp_busy && epp_wr_r) begin
            pd_out_r <= epp_is_addr_r ? epp_addr_r : epp_data_r;
        end else begin
            pd_out_r <= data_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_oe_r <= 1'b1;
        end else if (port_mode == ppe_pkg::MODE_PRINTER) begin
            pd_oe_r <= 1'b1;
        end else if (epp_busy) begin
            pd_oe_r <= epp_wr_r;
        end else begin
            pd_oe_r <= !ctl_r[ppe_pkg::CT_DIR_BIT];
        end
    end

    // Between EPP cycles the pins follow the control register as usual.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_r <= 1'b1;
            linefeed_r <= 1'b1;
            select_r <= 1'b1;
        end else if (epp_busy) begin
            strobe_r <= !epp_wr_r;
            linefeed_r <= !(strobe_up && !epp_is_addr_r);
            select_r <= !(strobe_up && epp_is_addr_r);
        end else begin
            strobe_r <= !ctl_r[ppe_pkg::CT_STROBE_BIT];
            linefeed_r <= !ctl_r[ppe_pkg::CT_LINEFEED_BIT];
            select_r <= !ctl_r[ppe_pkg::CT_SELECT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_r <= 1'b0;
        end else begin
            init_r <= ctl_r[ppe_pkg::CT_INIT_BIT];
        end
    end

    assign port_data_pins_out = pd_out_r;
    assign port_data_pins_oe = pd_oe_r;
    assign strobe_pin_n = strobe_r;
    assign linefeed_pin = linefeed_r;
    assign init_pin = init_r;
    assign select_in_pin = select_r;

    // -------------------------------------------------------------------
    // Acknowledge interrupt
    // -------------------------------------------------------------------
    logic irq_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_prev_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ack_prev_r <= ack_sync;
            irq_r <= ack_sync && !ack_prev_r && ctl_r[ppe_pkg::CT_IRQ_EN_BIT];
        end
    end

    assign ack_irq = irq_r;

endmodule

/* sim/ppe_port_monitor.sv */
`timescale 1ns/100ps
module ppe_port_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic io_done,
    input wire logic [7:0] io_rdata,
    input wire logic [1:0] port_mode,
    input wire logic port_data_pins_oe,
    input wire logic strobe_pin_n,
    input wire logic linefeed_pin,
    input wire logic select_in_pin,
    input wire logic ack_irq
);
    // ----------------
    // Strobe length
    // ----------------
    // The count saturates so that a stuck strobe cannot wrap back into range.
    logic [12:0] stb_cnt_r;
    wire epp = port_mode == ppe_pkg::MODE_EPP;
    always_ff @(posedge clk) begin
        if (!rst_n || !epp || linefeed_pin) begin
            stb_cnt_r <= 13'h0000;
        end else if (stb_cnt_r != 13'h1FFF) begin
            stb_cnt_r <= stb_cnt_r + 13'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_stb_end;
        epp && $rose(linefeed_pin);
    endsequence
    a_strobe_done: assert property (s_stb_end |-> ##[0:1] io_done)
        else $error("strobe ended without completion");
    a_cycle_bound: assert property (stb_cnt_r <= 13'(ppe_pkg::TMO_CYCLES))
        else $error("data strobe held past the time limit");
    a_write_drives: assert property (epp && !linefeed_pin && !strobe_pin_n |-> port_data_pins_oe)
        else $error("write cycle without data drive");
    a_read_floats: assert property (epp && !linefeed_pin && strobe_pin_n |-> !port_data_pins_oe)
        else $error("read cycle with data drive");
    a_strobe_excl: assert property (epp && !select_in_pin |-> linefeed_pin)
        else $error("address and data strobes together");
    a_printer_drives: assert property ((port_mode == ppe_pkg::MODE_PRINTER) [*3] |-> port_data_pins_oe)
        else $error("printer mode data not driven");
    a_rdata_held: assert property ($changed(io_rdata) |-> io_done)
        else $error("read data changed outside an answer");
    a_irq_single: assert property (ack_irq |=> !ack_irq)
        else $error("interrupt pulse too long");
endmodule
bind ppe_port ppe_port_monitor ppe_port_monitor_inst (.*);

/* sim/ppe_periph.sv */
`timescale 1ns/100ps
module ppe_periph (
    input wire logic clk,
    input wire logic [7:0] dly,
    input wire logic [7:0] rd_byte,
    input wire logic [7:0] port_data_pins_out,
    input wire logic port_data_pins_oe,
    input wire logic strobe_pin_n,
    input wire logic linefeed_pin,
    input wire logic select_in_pin,
    output logic wait_pin_n,
    output logic [7:0] port_data_pins_in,
    output logic [7:0] got,
    output logic got_addr
);
    // ----------------
    // Peripheral
    // ----------------
    // A delay of 8'hFF never answers; a released bus shows its last level inverted.
    logic [7:0] cnt_r = 8'h00;
    logic [7:0] last_r = 8'h00;
    logic wait_r = 1'b0;
    wire stb = !linefeed_pin || !select_in_pin;
    assign wait_pin_n = wait_r;
    assign port_data_pins_in = port_data_pins_oe === 1'b1 ? port_data_pins_out :
        (stb && strobe_pin_n) ? rd_byte : ~last_r;
    always @(posedge clk) begin
        if (port_data_pins_oe === 1'b1) begin
            last_r <= port_data_pins_out;
        end
        cnt_r <= stb ? cnt_r + 8'h01 : 8'h00;
        wait_r <= stb && cnt_r >= dly && dly != 8'hFF;
        if (stb && port_data_pins_oe) begin
            got <= port_data_pins_in;
            got_addr <= !select_in_pin;
        end
    end
endmodule

/* sim/tb_ppe_port.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_ppe_port;
    typedef struct packed {
        logic w;
        logic [2:0] o;
        logic [7:0] d;
        logic [3:0] pin;
        logic [7:0] e;
    } ppe_row_type;
    localparam logic [15:0] BASE = 16'h0240;
    localparam ppe_row_type ROWS [7] = '{'{1'b1, 3'h2, 8'hF4, 4'h0, 8'h00},
        '{1'b0, 3'h2, 8'h00, 4'h0, 8'h34}, '{1'b1, 3'h0, 8'hA5, 4'h0, 8'h00},
        '{1'b0, 3'h0, 8'h00, 4'h0, 8'hA5}, '{1'b0, 3'h1, 8'h00, 4'h5, 8'hA8},
        '{1'b0, 3'h1, 8'h00, 4'hA, 8'hD0}, '{1'b0, 3'h5, 8'h00, 4'h0, 8'hFF}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic io_valid = 1'b0;
    logic io_write = 1'b0;
    logic tmo_clear_mode = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [15:0] base_addr = BASE;
    logic [1:0] port_mode = ppe_pkg::MODE_PRINTER;
    logic fault_pin = 1'b0, online_pin = 1'b0, paper_out_pin = 1'b0, acknowledge_in = 1'b0;
    logic [7:0] io_wdata = 8'h00, dly = 8'h00, rd_byte = 8'h00;
    logic io_ready, io_done, port_data_pins_oe, strobe_pin_n, linefeed_pin, init_pin;
    logic select_in_pin, wait_pin_n, ack_irq, got_addr;
    logic [7:0] io_rdata, port_data_pins_in, port_data_pins_out, got;
    int err_total = 0, compares = 0, takes = 0, dones = 0, irqs = 0;
    ppe_port ppe_port_inst (.*);
    ppe_periph ppe_periph_inst (.*);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        takes += int'(io_valid && io_ready);
        dones += int'(io_done === 1'b1);
        irqs += int'(ack_irq === 1'b1);
    end
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input int lim,
                      output logic [7:0] r, output logic dn);
        int n;
        @(posedge clk);
        io_valid <= 1'b1;
        io_write <= w;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk);
        while (io_ready !== 1'b1) @(posedge clk);
        io_valid <= 1'b0;
        for (n = 0; io_done !== 1'b1 && n < lim; n++) @(posedge clk);
        dn = io_done === 1'b1;
        r = io_rdata;
    endtask
    task automatic give_verdict();
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    initial begin
        logic [7:0] r;
        logic [7:0] v;
        logic dn;
        int k;
        int m;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("idle pins", 4'hE, {strobe_pin_n, linefeed_pin, select_in_pin, init_pin})
        io(1'b0, BASE, 8'h00, 3000, r, dn);
        `CHK("data reset", 8'h00, r)
        foreach (ROWS[i]) begin
            {acknowledge_in, paper_out_pin, online_pin, fault_pin} <= ROWS[i].pin;
            repeat (3) @(posedge clk);
            io(ROWS[i].w, BASE + 16'(ROWS[i].o), ROWS[i].d, 3000, r, dn);
            if (!ROWS[i].w) `CHK("row read", ROWS[i].e, r)
        end
        for (int i = 0; i < 4; i++) begin
            if (i == 2) port_mode <= ppe_pkg::MODE_BIDIR;
            io(1'b1, BASE + 16'h0002, i[0] ? 8'h04 : (i[1] ? 8'h24 : 8'h0B), 3000, r, dn);
            repeat (2) @(posedge clk);
            if (i < 2) `CHK("ctl pins", i[0] ? 4'hF : 4'h0,
                {strobe_pin_n, linefeed_pin, select_in_pin, init_pin})
            else `CHK("direction", i[0], port_data_pins_oe)
        end
        io(1'b0, BASE + 16'h0008, 8'h00, 20, r, dn);
        `CHK("miss", 1'b0, dn)
        base_addr <= 16'h0378;
        io(1'b0, 16'h037A, 8'h00, 3000, r, dn);
        `CHK("moved base", 8'h04, r)
        io(1'b0, BASE + 16'h0002, 8'h00, 20, r, dn);
        `CHK("old base", 1'b0, dn)
        base_addr <= BASE;
        for (int i = 1; i >= 0; i--) begin
            io(1'b1, BASE + 16'h0002, i[0] ? 8'h14 : 8'h04, 3000, r, dn);
            acknowledge_in <= 1'b0;
            repeat (4) @(posedge clk);
            k = irqs;
            acknowledge_in <= 1'b1;
            repeat (6) @(posedge clk);
            `CHK("irq count", i, irqs - k)
        end
        port_mode <= ppe_pkg::MODE_EPP;
        io(1'b1, BASE + 16'h0002, 8'h04, 3000, r, dn);
        for (int i = 0; i < 10; i++) begin
            dly <= i < 5 ? 8'h00 : 8'h14;
            v = 8'hC0 ^ 8'(i);
            rd_byte <= ~v;
            io(1'b1, BASE + 16'(3 + i % 5), v, 3000, r, dn);
            `CHK("periph byte", {i % 5 == 0, v}, {got_addr, got})
            io(1'b0, BASE + 16'(3 + i % 5), 8'h00, 3000, r, dn);
            `CHK("epp read", ~v, r)
        end
        dly <= 8'hFF;
        for (int i = 0; i < 2; i++) begin
            tmo_clear_mode <= i[0];
            io(1'b1, BASE + 16'h0004, 8'h55, 3000, r, dn);
            `CHK("timeout answer", 1'b1, dn)
            io(1'b0, BASE + 16'h0001, 8'h00, 3000, r, dn);
            `CHK("timeout flag", 1'b1, r[0])
            io(1'b1, BASE + 16'h0001, 8'h00, 3000, r, dn);
            io(1'b0, BASE + 16'h0001, 8'h00, 3000, r, dn);
            `CHK("flag after zero", ~i[0], r[0])
            io(1'b1, BASE + 16'h0001, 8'h01, 3000, r, dn);
            io(1'b0, BASE + 16'h0001, 8'h00, 3000, r, dn);
            `CHK("flag cleared", 1'b0, r[0])
        end
        dly <= 8'h32;
        io_write <= 1'b1;
        io_addr <= BASE + 16'h0004;
        io_valid <= 1'b1;
        k = takes;
        m = dones;
        repeat (12) @(posedge clk);
        `CHK("queue full", 1'b0, io_ready)
        io_valid <= 1'b0;
        for (int n = 0; n < 2000 && dones - m != takes - k; n++) @(posedge clk);
        `CHK("queue drained", takes - k, dones - m)
        give_verdict();
    end
endmodule
